/* design/smc_pkg.sv */
// package: constants and carriers for the serial master/slave controller
package smc_pkg;

    localparam logic [4:0] WORD_LEN_FULL = 5'h0;
    localparam logic [5:0] WORD_BITS_MAX = 6'h20;
    localparam logic [1:0] WORD_CNT_BURST = 2'h1;
    localparam logic [31:0] DATA_RST = 32'h0;
    localparam logic [16:0] DIV_CNT_RST = 17'h0;
    localparam logic [4:0] PATTERN_TOP = 5'h1E;

    typedef struct packed {
        logic slave_mode;
        logic lsb_first;
        logic clock_idle_polarity;
        logic tx_neg;
        logic rx_neg;
        logic variable_clock_enable;
        logic select_polarity;
        logic select_level_trigger;
        logic automatic_select_enable;
        logic [1:0] select_output_control;
        logic [1:0] word_count;
        logic [4:0] word_length_field;
        logic [15:0] primary_divisor;
        logic [15:0] secondary_divisor;
        logic [31:0] clock_pattern_bits;
    } smc_cfg_t;

    typedef struct packed {
        logic [31:0] word1;
        logic [31:0] word0;
    } smc_words_t;

    typedef enum logic [1:0] {
        SMC_IDLE,
        SMC_MASTER,
        SMC_SLAVE,
        SMC_RELEASE
    } smc_state_t;

endpackage

/* design/smc_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module smc_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    output logic level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            lvl_ff <= RST_VAL;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // change counts once stages two and three agree
            if (s2_ff == s3_ff) begin
                lvl_ff <= s3_ff;
            end
        end
    end

    assign level_out = lvl_ff;
endmodule // smc_sync3
`default_nettype wire

/* design/smc_ctrl.sv */
// serial master/slave controller core
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire smc_pkg::smc_cfg_t cfg_in,
    input wire smc_pkg::smc_words_t tx_words_in,
    input wire logic start_in,
    input wire logic clear_flags_in,
    input wire logic sclk_in,
    input wire logic sel_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    output logic busy_out,
    output logic done_flag_out,
    output logic level_done_flag_out,
    output smc_pkg::smc_words_t rx_words_out,
    output logic sclk_out,
    output logic sclk_oe_out,
    output logic [1:0] sel_out,
    output logic [1:0] sel_oe_out,
    output logic mosi_out,
    output logic mosi_oe_out,
    output logic miso_out,
    output logic miso_oe_out
);
    typedef struct packed {
        smc_pkg::smc_state_t st;
        logic [16:0] div_cnt;
        logic [3:0] cyc_idx;
        logic [4:0] bit_idx;
        logic word_idx;
        logic all_rx;
        logic sclk;
        logic sclk_prev;
        logic sel_prev;
        logic mosi;
        logic miso;
        logic busy;
        logic miso_oe;
        logic done_flag;
        logic lvl_flag;
        logic [1:0] sel;
        logic [1:0] sel_oe;
        smc_pkg::smc_words_t tx;
        smc_pkg::smc_words_t rx;
    } smc_regs_t;

    smc_regs_t r_ff;
    smc_regs_t nxt_r;
    logic sclk_sync;
    logic sel_sync;
    logic mosi_sync;

    smc_sync3 #(.RST_VAL(1'b0)) u_sync_sclk (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(sclk_in),
        .level_out(sclk_sync)
    );
    smc_sync3 #(.RST_VAL(1'b1)) u_sync_sel (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(sel_in),
        .level_out(sel_sync)
    );
    smc_sync3 #(.RST_VAL(1'b0)) u_sync_mosi (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(mosi_in),
        .level_out(mosi_sync)
    );

    function automatic logic [5:0] word_len(input smc_pkg::smc_cfg_t c);
        if (c.word_length_field == smc_pkg::WORD_LEN_FULL) begin
            return smc_pkg::WORD_BITS_MAX;
        end
        return {1'b0, c.word_length_field};
    endfunction

    function automatic logic [4:0] bit_pos(input smc_pkg::smc_cfg_t c,
                                          input logic [4:0] idx);
        logic [5:0] p;
        p = word_len(c) - 6'h1 - {1'b0, idx};
        if (c.lsb_first) begin
            return idx;
        end
        return p[4:0];
    endfunction

    function automatic logic tx_bit(input smc_regs_t s,
                                    input smc_pkg::smc_cfg_t c);
        logic [4:0] p;
        p = bit_pos(c, s.bit_idx);
        return s.word_idx ? s.tx.word1[p] : s.tx.word0[p];
    endfunction

    // divisor of one serial cycle, pattern groups counted from the top
    function automatic logic [15:0] pick_div(input smc_pkg::smc_cfg_t c,
                                             input logic [3:0] idx);
        logic [4:0] sh;
        logic [1:0] grp;
        sh = smc_pkg::PATTERN_TOP - {idx, 1'b0};
        grp = 2'(c.clock_pattern_bits >> sh);
        if (c.variable_clock_enable && (grp != 2'h0)) begin
            return c.secondary_divisor;
        end
        return c.primary_divisor;
    endfunction

    // one serial clock edge: transmit and receive in the same pass
    function automatic smc_regs_t clk_edge(input smc_regs_t s,
                                           input smc_pkg::smc_cfg_t c,
                                           input logic new_clk,
                                           input logic din);
        smc_regs_t o;
        logic [4:0] p;
        logic last_bit;
        logic last_word;
        o = s;
        p = bit_pos(c, s.bit_idx);
        last_bit = ({1'b0, s.bit_idx} == word_len(c) - 6'h1);
        last_word = (c.word_count == smc_pkg::WORD_CNT_BURST) ? 1'b1 : 1'b0;
        if ((new_clk ^ c.tx_neg) && !s.all_rx) begin
            if (c.slave_mode) begin
                o.miso = tx_bit(s, c);
            end else begin
                o.mosi = tx_bit(s, c);
            end
        end
        if ((new_clk ^ c.rx_neg) && !s.all_rx) begin
            if (s.word_idx) begin
                o.rx.word1[p] = din;
            end else begin
                o.rx.word0[p] = din;
            end
            if (last_bit) begin
                o.bit_idx = 5'h0;
                if (s.word_idx == last_word) begin
                    o.all_rx = 1'b1;
                end else begin
                    o.word_idx = 1'b1;
                end
            end else begin
                o.bit_idx = s.bit_idx + 5'h1;
            end
        end
        return o;
    endfunction

    always_comb begin
        logic sel_act;
        logic sel_fall;
        logic sel_rise;
        logic tick;
        logic new_clk;
        logic [1:0] line_en;
        logic [15:0] div_sel;
        logic finish;
        nxt_r = r_ff;
        // flags hold only this cycle's sets here, old state merged below
        nxt_r.done_flag = 1'b0;
        nxt_r.lvl_flag = 1'b0;
        sel_act = sel_sync ~^ cfg_in.select_polarity;
        sel_rise = sel_act && !r_ff.sel_prev;
        sel_fall = !sel_act && r_ff.sel_prev;
        tick = (r_ff.div_cnt == smc_pkg::DIV_CNT_RST);
        new_clk = !r_ff.sclk;
        div_sel = pick_div(cfg_in, r_ff.cyc_idx);
        finish = 1'b0;
        // one line at a time, line zero wins
        line_en = cfg_in.select_output_control[0] ? 2'h1 :
                  (cfg_in.select_output_control & 2'h2);
        nxt_r.sel_prev = sel_act;
        nxt_r.sclk_prev = sclk_sync;

        unique case (r_ff.st)
            smc_pkg::SMC_IDLE: begin
                nxt_r.sclk = cfg_in.clock_idle_polarity;
                nxt_r.bit_idx = 5'h0;
                nxt_r.word_idx = 1'b0;
                nxt_r.all_rx = 1'b0;
                nxt_r.cyc_idx = 4'h0;
                // first pattern group already governs the first cycle
                nxt_r.div_cnt = {1'b0, pick_div(cfg_in, 4'h0)};
                nxt_r.tx = tx_words_in;
                if (cfg_in.slave_mode) begin
                    nxt_r.miso = tx_bit(nxt_r, cfg_in);
                    if (cfg_in.select_level_trigger ? sel_act
                                                    : sel_rise) begin
                        nxt_r.st = smc_pkg::SMC_SLAVE;
                        nxt_r.busy = 1'b1;
                    end
                end else if (start_in) begin
                    nxt_r.mosi = tx_bit(nxt_r, cfg_in);
                    nxt_r.st = smc_pkg::SMC_MASTER;
                    nxt_r.busy = 1'b1;
                end
            end
            smc_pkg::SMC_MASTER: begin
                if (tick) begin
                    nxt_r = clk_edge(nxt_r, cfg_in, new_clk, miso_in);
                    nxt_r.sclk = new_clk;
                    // returning to idle closes one serial cycle
                    if (new_clk == cfg_in.clock_idle_polarity) begin
                        nxt_r.cyc_idx = r_ff.cyc_idx + 4'h1;
                        div_sel = pick_div(cfg_in, nxt_r.cyc_idx);
                        if (nxt_r.all_rx) begin
                            finish = 1'b1;
                        end
                    end
                    // divisor zero toggles every cycle, fastest rate
                    nxt_r.div_cnt = {1'b0, div_sel};
                end else begin
                    nxt_r.div_cnt = r_ff.div_cnt - 17'h1;
                end
                if (finish || cfg_in.slave_mode) begin
                    nxt_r.st = smc_pkg::SMC_IDLE;
                    nxt_r.busy = 1'b0;
                    nxt_r.done_flag = 1'b1;
                    nxt_r.sclk = cfg_in.clock_idle_polarity;
                end
            end
            smc_pkg::SMC_SLAVE: begin
                // clock belongs to the external master
                if (sclk_sync != r_ff.sclk_prev) begin
                    nxt_r = clk_edge(nxt_r, cfg_in, sclk_sync, mosi_sync);
                end
                if (cfg_in.select_level_trigger) begin
                    if (!sel_act) begin
                        nxt_r.st = smc_pkg::SMC_IDLE;
                        nxt_r.busy = 1'b0;
                        nxt_r.done_flag = 1'b1;
                        // last bit and select drop in one cycle: complete
                        nxt_r.lvl_flag = nxt_r.all_rx;
                    end else if (nxt_r.all_rx) begin
                        nxt_r.st = smc_pkg::SMC_RELEASE;
                        nxt_r.busy = 1'b0;
                        nxt_r.done_flag = 1'b1;
                        nxt_r.lvl_flag = 1'b1;
                    end
                end else if (sel_fall) begin
                    nxt_r.st = smc_pkg::SMC_IDLE;
                    nxt_r.busy = 1'b0;
                    nxt_r.done_flag = 1'b1;
                end
                if (!cfg_in.slave_mode) begin
                    nxt_r.st = smc_pkg::SMC_IDLE;
                    nxt_r.busy = 1'b0;
                end
            end
            smc_pkg::SMC_RELEASE: begin
                // wait for select to drop before a new frame
                if (!sel_act || !cfg_in.slave_mode) begin
                    nxt_r.st = smc_pkg::SMC_IDLE;
                end
            end
        endcase

        // a set in this same cycle beats the clear
        nxt_r.done_flag = nxt_r.done_flag
                          || (r_ff.done_flag && !clear_flags_in);
        nxt_r.lvl_flag = nxt_r.lvl_flag
                         || (r_ff.lvl_flag && !clear_flags_in);

        if (cfg_in.slave_mode) begin
            nxt_r.sel_oe = 2'h0;
            nxt_r.sel = {2{!cfg_in.select_polarity}};
            nxt_r.miso_oe = nxt_r.busy;
        end else begin
            nxt_r.sel_oe = 2'h3;
            nxt_r.miso_oe = 1'b0;
            for (int i = 0; i < 2; i++) begin
                if (cfg_in.automatic_select_enable) begin
                    nxt_r.sel[i] = (line_en[i] && nxt_r.busy)
                                   ~^ cfg_in.select_polarity;
                end else begin
                    nxt_r.sel[i] = cfg_in.select_output_control[i]
                                   ~^ cfg_in.select_polarity;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_ff.st <= smc_pkg::SMC_IDLE;
            r_ff.div_cnt <= smc_pkg::DIV_CNT_RST;
            r_ff.cyc_idx <= 4'h0;
            r_ff.bit_idx <= 5'h0;
            r_ff.word_idx <= 1'b0;
            r_ff.all_rx <= 1'b0;
            r_ff.sclk <= 1'b0;
            r_ff.sclk_prev <= 1'b0;
            r_ff.sel_prev <= 1'b0;
            r_ff.mosi <= 1'b0;
            r_ff.miso <= 1'b0;
            r_ff.busy <= 1'b0;
            r_ff.miso_oe <= 1'b0;
            r_ff.done_flag <= 1'b0;
            r_ff.lvl_flag <= 1'b0;
            r_ff.sel <= 2'h3;
            r_ff.sel_oe <= 2'h0;
            r_ff.tx <= {smc_pkg::DATA_RST, smc_pkg::DATA_RST};
            r_ff.rx <= {smc_pkg::DATA_RST, smc_pkg::DATA_RST};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign busy_out = r_ff.busy;
    assign done_flag_out = r_ff.done_flag;
    assign level_done_flag_out = r_ff.lvl_flag;
    assign rx_words_out = r_ff.rx;
    assign sclk_out = r_ff.sclk;
    assign sclk_oe_out = r_ff.sel_oe[0];
    assign sel_out = r_ff.sel;
    assign sel_oe_out = r_ff.sel_oe;
    assign mosi_out = r_ff.mosi;
    assign mosi_oe_out = r_ff.sel_oe[0];
    assign miso_out = r_ff.miso;
    assign miso_oe_out = r_ff.miso_oe;
endmodule // smc_ctrl
`default_nettype wire

/* testbench/smc_ctrl_asserts.sv */
// port assertions for the serial controller
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire smc_pkg::smc_cfg_t cfg_in,
    input wire logic start_in,
    input wire logic sel_in,
    input wire logic busy_out,
    input wire logic done_flag_out,
    input wire logic level_done_flag_out,
    input wire logic sclk_out,
    input wire logic sclk_oe_out,
    input wire logic [1:0] sel_out,
    input wire logic [1:0] sel_oe_out,
    input wire logic mosi_oe_out,
    input wire logic miso_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [16:0] cnt_ff;
    logic seen_ff;
    logic sclk_q_ff;
    logic chg;
    assign chg = sclk_out != sclk_q_ff;
    // cycles since the last serial clock change
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff <= 17'h0;
            seen_ff <= 1'b0;
            sclk_q_ff <= 1'b0;
        end else begin
            cnt_ff <= chg ? 17'h0 : cnt_ff + 17'h1;
            seen_ff <= busy_out && (chg || seen_ff);
            sclk_q_ff <= sclk_out;
        end
    end
    AST_DIV: assert property (chg && seen_ff && busy_out &&
        !cfg_in.variable_clock_enable && !cfg_in.slave_mode
        |-> cnt_ff == {1'b0, cfg_in.primary_divisor})
        else $error("serial half period wrong");
    AST_IDLE_CLK: assert property ((!cfg_in.slave_mode && !busy_out)
        ##1 (!busy_out && $stable(cfg_in))
        |-> sclk_out == cfg_in.clock_idle_polarity)
        else $error("serial clock idle level wrong");
    AST_START: assert property (start_in && !busy_out &&
        !$past(busy_out) && !cfg_in.slave_mode |=> busy_out)
        else $error("start not taken");
    AST_DONE_BUSY: assert property ($fell(busy_out) |-> done_flag_out)
        else $error("transfer ended without flag");
    AST_LVL_FLAG: assert property ($rose(level_done_flag_out)
        |-> cfg_in.slave_mode && cfg_in.select_level_trigger)
        else $error("level flag outside level slave");
    AST_EDGE_HOLD: assert property ((cfg_in.slave_mode &&
        !cfg_in.select_level_trigger &&
        sel_in == cfg_in.select_polarity) [*6] |-> !$rose(done_flag_out))
        else $error("edge slave done while select active");
    AST_SEL_AUTO: assert property ($past(rst_n_in) &&
        !cfg_in.slave_mode && cfg_in.automatic_select_enable &&
        cfg_in.select_output_control[0] && $stable(cfg_in)
        |-> sel_out == {~cfg_in.select_polarity,
        busy_out ~^ cfg_in.select_polarity})
        else $error("automatic select level wrong");
    AST_SEL_MAN: assert property ($past(rst_n_in) &&
        !cfg_in.slave_mode && !cfg_in.automatic_select_enable &&
        $stable(cfg_in) |-> sel_out ==
        (cfg_in.select_output_control ^ {2{~cfg_in.select_polarity}}))
        else $error("manual select level wrong");
    AST_OE_SLV: assert property (cfg_in.slave_mode ##1
        cfg_in.slave_mode |-> sel_oe_out == 2'h0 && !sclk_oe_out &&
        !mosi_oe_out)
        else $error("slave drives master pins");
    AST_MISO_OE: assert property ($stable(cfg_in.slave_mode)
        |-> miso_oe_out == (busy_out && cfg_in.slave_mode))
        else $error("miso enable wrong");
endmodule // smc_ctrl_asserts
bind smc_ctrl smc_ctrl_asserts i_chk (.clk_in, .rst_n_in, .cfg_in,
    .start_in, .sel_in, .busy_out, .done_flag_out, .level_done_flag_out,
    .sclk_out, .sclk_oe_out, .sel_out, .sel_oe_out, .mosi_oe_out,
    .miso_oe_out);
`default_nettype wire

/* testbench/smc_peer.sv */
// off-chip slave model on select line zero, active low
`timescale 1ns/10ps
`default_nettype none
module smc_peer (
    input wire logic sclk_in,
    input wire logic sel_in,
    input wire logic mosi_in,
    input wire logic rise_in,
    input wire logic [63:0] load_in,
    output logic miso_out,
    output logic [63:0] got_out
);
    logic [63:0] sh;
    initial miso_out = 1'b0;
    initial got_out = 64'h0;
    always @(negedge sel_in) begin
        sh = load_in;
        got_out = 64'h0;
        miso_out = sh[63];
    end
    // sample on one edge, shift out on the other
    always @(sclk_in) begin
        if (!sel_in && sclk_in == rise_in)
            got_out = {got_out[62:0], mosi_in};
        else if (!sel_in) begin
            sh = sh << 1;
            miso_out = sh[63];
        end
    end
    always @(posedge sel_in) miso_out = ~miso_out;
endmodule // smc_peer
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the serial controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_in, rst_n_in, start_in, clear_flags_in;
    logic sclk_in, sel_in, mosi_in, miso_in, prise;
    logic busy_out, done_flag_out, level_done_flag_out, sclk_out;
    logic sclk_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out;
    logic [1:0] sel_out, sel_oe_out;
    logic [63:0] pload, pgot;
    smc_pkg::smc_cfg_t cfg_in;
    smc_pkg::smc_words_t tx_words_in, rx_words_out;
    int n_fail, checks, cyc;
    smc_ctrl i_dut (.clk_in, .rst_n_in, .cfg_in, .tx_words_in, .start_in,
        .clear_flags_in, .sclk_in, .sel_in, .mosi_in, .miso_in, .busy_out,
        .done_flag_out, .level_done_flag_out, .rx_words_out, .sclk_out,
        .sclk_oe_out, .sel_out, .sel_oe_out, .mosi_out, .mosi_oe_out,
        .miso_out, .miso_oe_out);
    smc_peer i_peer (.sclk_in(sclk_out), .sel_in(sel_out[0]),
        .mosi_in(mosi_out), .rise_in(prise), .load_in(pload),
        .miso_out(miso_in), .got_out(pgot));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            test_done;
        end
    end
    // serial stream, first bit at the top
    function automatic logic [63:0] ser(smc_pkg::smc_words_t w, int n,
        int nw, logic lsb);
        logic [63:0] s;
        logic [31:0] x;
        s = 64'h0;
        for (int i = 0; i < n * nw; i++) begin
            x = (i < n) ? w.word0 : w.word1;
            s[63 - i] = x[lsb ? i % n : n - 1 - i % n];
        end
        return s;
    endfunction
    function automatic smc_pkg::smc_words_t des(logic [63:0] s, int n,
        int nw, logic lsb);
        logic [63:0] w;
        w = 64'h0;
        for (int i = 0; i < n * nw; i++)
            w[(i / n) * 32 + (lsb ? i % n : n - 1 - i % n)] = s[63 - i];
        return w;
    endfunction
    task automatic clrf;
        clear_flags_in = 1'b1;
        @(negedge clk_in);
        clear_flags_in = 1'b0;
    endtask
    task automatic mxfer(input logic [4:0] len, input logic [1:0] wc,
        input logic lsb, input logic idle, output int t);
        int n, nw;
        n = (len == 5'h0) ? 32 : int'(len);
        nw = (wc == 2'h1) ? 2 : 1;
        cfg_in.word_length_field = len;
        cfg_in.word_count = wc;
        cfg_in.lsb_first = lsb;
        cfg_in.clock_idle_polarity = idle;
        cfg_in.tx_neg = ~idle;
        cfg_in.rx_neg = idle;
        prise = ~idle;
        repeat (3) @(negedge clk_in);
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        chk(64'(busy_out), 64'h1);
        chk(64'(sel_out), 64'h2);
        t = 0;
        while (busy_out === 1'b1 && t < 5000) begin
            @(negedge clk_in);
            t++;
        end
        chk(64'(done_flag_out), 64'h1);
        chk(64'(sel_out), 64'h3);
        chk(64'(sclk_out), 64'(idle));
        chk(rx_words_out & des(~64'h0, n, nw, lsb),
            des(pload, n, nw, lsb));
        chk(pgot, ser(tx_words_in, n, nw, lsb) >> (64 - n * nw));
        clrf;
    endtask
    // external master framing, select active low, sample on rise
    task automatic sframe(input logic [63:0] s, input int nb,
        input logic drop, output logic [63:0] m);
        m = 64'h0;
        sel_in = 1'b0;
        repeat (8) @(negedge clk_in);
        for (int i = 0; i < nb; i++) begin
            mosi_in = s[63 - i];
            repeat (8) @(negedge clk_in);
            // slave's bit as the external master would latch it
            m = {m[62:0], miso_out};
            sclk_in = 1'b1;
            repeat (8) @(negedge clk_in);
            sclk_in = 1'b0;
        end
        repeat (12) @(negedge clk_in);
        if (drop)
            sel_in = 1'b1;
        repeat (12) @(negedge clk_in);
    endtask
    initial begin
        int t;
        logic [63:0] m;
        {start_in, clear_flags_in, sclk_in, mosi_in, prise} = 5'h1;
        sel_in = 1'b1;
        cfg_in = '0;
        cfg_in.automatic_select_enable = 1'b1;
        cfg_in.select_output_control = 2'h1;
        cfg_in.select_level_trigger = 1'b1;
        tx_words_in = 64'hC3A5_1E69_5AF0_9D2B;
        pload = 64'h9B6D_E217_4C8F_30A5;
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        chk(64'(busy_out), 64'h0);
        chk(64'(sel_out), 64'h3);
        mxfer(5'h08, 2'h0, 1'b0, 1'b0, t);
        cfg_in.primary_divisor = 16'h2;
        mxfer(5'h04, 2'h1, 1'b1, 1'b0, t);
        cfg_in.primary_divisor = 16'h1;
        mxfer(5'h00, 2'h0, 1'b0, 1'b1, t);
        cfg_in.primary_divisor = 16'h0;
        cfg_in.secondary_divisor = 16'h3;
        cfg_in.clock_pattern_bits = 32'h4000_0000;
        cfg_in.variable_clock_enable = 1'b1;
        mxfer(5'h10, 2'h0, 1'b0, 1'b0, t);
        chk(64'(t >= 36 && t <= 42), 64'h1);
        cfg_in.variable_clock_enable = 1'b0;
        cfg_in.automatic_select_enable = 1'b0;
        cfg_in.select_output_control = 2'h2;
        repeat (2) @(negedge clk_in);
        chk(64'(sel_out), 64'h1);
        cfg_in.select_polarity = 1'b1;
        repeat (2) @(negedge clk_in);
        chk(64'(sel_out), 64'h2);
        cfg_in.select_polarity = 1'b0;
        cfg_in.slave_mode = 1'b1;
        cfg_in.word_length_field = 5'h04;
        cfg_in.word_count = 2'h0;
        repeat (4) @(negedge clk_in);
        chk(64'(sel_oe_out), 64'h0);
        sframe(64'hB000_0000_0000_0000, 4, 1'b1, m);
        chk(64'({done_flag_out, level_done_flag_out}), 64'h3);
        chk(rx_words_out & 64'hF, 64'hB);
        chk(m, ser(tx_words_in, 4, 1, 1'b0) >> 60);
        clrf;
        sframe(64'h0, 2, 1'b1, m);
        chk(64'({done_flag_out, level_done_flag_out}), 64'h2);
        chk(m, ser(tx_words_in, 4, 1, 1'b0) >> 62);
        clrf;
        cfg_in.select_level_trigger = 1'b0;
        sframe(64'h5000_0000_0000_0000, 4, 1'b0, m);
        chk(64'(done_flag_out), 64'h0);
        chk(rx_words_out & 64'hF, 64'h5);
        chk(m, ser(tx_words_in, 4, 1, 1'b0) >> 60);
        sel_in = 1'b1;
        repeat (12) @(negedge clk_in);
        chk(64'(done_flag_out), 64'h1);
        test_done;
    end
endmodule // testbench
`default_nettype wire
